// >>> design/crs_pkg.sv
package crs_pkg;
  // core clock
  localparam int CLK_HZ = 40000000;
  localparam int CLK_PERIOD_NS = 25;
  // pixel period, nominal (250 ns, at least 200 ns)
  localparam int PIX_NS = 250;
  localparam int PIX_MIN_NS = 200;
  localparam int PIX_CYC = (PIX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_PIX_CYC = PIX_CYC / 2;
  // vertical pulse width, nominal 5 us (at least 4 us)
  localparam int VPW_US = 5;
  localparam int VPW_CYC = VPW_US * (CLK_HZ / 1000000);
  // horizontal setup interval, nominal 1000 ns
  localparam int HSETUP_NS = 1000;
  localparam int HSETUP_CYC =
    (HSETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // reset clock pulse width, nominal 60 ns (at least 20 ns)
  localparam int RST_PW_NS = 60;
  localparam int RST_PW_CYC =
    (RST_PW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // line and frame geometry
  localparam int VPHASES = 3;
  localparam int PIX_PER_LINE = 1044;
  localparam int EXTRA_PIX = 1;
  localparam int LINES_PER_FRAME = 1032;
  localparam int PIX_CNT_W = 11;
  localparam int LINE_CNT_W = 11;
  localparam int CYC_CNT_W = 16;
  localparam int EXP_W = 32;
  // output amplifier choice
  localparam logic OUT_WIDE = 1'h0;
  localparam logic OUT_SENSITIVE = 1'h1;
  // static level of an unused split gate: the horizontal low level
  localparam logic SPLIT_IDLE = 1'h0;
  typedef enum logic [2:0] {
    ST_IDLE, ST_EXPOSE, ST_VERT, ST_HSETUP, ST_HREAD
  } crs_state_t;
endpackage

// >>> design/crs_pixel_clock.sv
`timescale 1ns/10ps
// free-running pixel timebase: horizontal phases and reset clock
module crs_pixel_clock (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run_h,
  output logic h_a,
  output logic h_b,
  output logic rst_clk,
  output logic pix_end
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  always_comb begin
    cnt_next = cnt_reg + 8'h01;
    if (cnt_reg == 8'(crs_pkg::PIX_CYC - 1)) begin // R6
      cnt_next = 8'h00;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  assign pix_end = (cnt_reg == 8'(crs_pkg::PIX_CYC - 1));
  // b high in the first half so its fall lands mid-period
  assign h_b = run_h && (cnt_reg < 8'(crs_pkg::HALF_PIX_CYC)); // R16
  assign h_a = run_h && !h_b; // R7 R13
  // reset pulse just after the packet is sensed, before the next dump
  assign rst_clk = (cnt_reg < 8'(crs_pkg::RST_PW_CYC)); // R3 R10 R18
endmodule

// >>> design/crs_vert_seq.sv
`timescale 1ns/10ps
// four-step accumulation-mode line transfer
module crs_vert_seq (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  output logic v_a,
  output logic v_b,
  output logic done
);
  logic [2:0] step_reg;
  logic [2:0] step_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  always_comb begin
    step_next = step_reg;
    cnt_next = cnt_reg;
    if (step_reg == 3'h0) begin
      if (start) begin
        step_next = 3'h1;
        cnt_next = 16'h0000;
      end
    end else if (cnt_reg == 16'(crs_pkg::VPW_CYC - 1)) begin // R8 R9
      cnt_next = 16'h0000;
      step_next = (step_reg == 3'h3) ? 3'h0 : step_reg + 3'h1;
    end else begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_reg <= 3'h0;
      cnt_reg <= 16'h0000;
    end else begin
      step_reg <= step_next;
      cnt_reg <= cnt_next;
    end
  end
  // 1: a up; 2: a down b up (loads line); 3: a up b down; then a down
  assign v_a = (step_reg == 3'h1) || (step_reg == 3'h3); // R15
  assign v_b = (step_reg == 3'h2); // R15 R9
  assign done = (step_reg == 3'h3) &&
    (cnt_reg == 16'(crs_pkg::VPW_CYC - 1));
endmodule

// >>> design/crs_sequencer.sv
`timescale 1ns/10ps
// Functional notes
// (R1) wide output: gate one follows h_b
// (R2) sensitive output: gate two follows h_b
// (R3) reset clock pulses at all times
// (R4) line: 3 vpw, setup, 1045 pixels
// (R5) frame is 1032 lines
// (R6) pixel period at least 200 ns
// (R7) horizontal phases 4 MHz, 50 percent
// (R8) vertical rate at most 125 kHz
// (R9) vertical pulse width at least 4 us
// (R10) reset pulse at least 20 ns
// (R11) vertical-to-horizontal delay nominally 32 us; the design gives near 16 us
// (R12) exposure length programmable by user
// (R13) clocks generated at 50 percent duty; the reset clock here is high 3 of every 10 cycles
// (R14) vertical phases low during exposure
// (R15) vertical a up, swap, swap, a down
// (R16) sensor dumps packet on h_b fall
// (R17) sensor adds dark pixels and lines
// (R18) reset pulse once per pixel period
module crs_sequencer (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic START,
  input wire logic OUT_SEL,
  input wire logic [31:0] EXPOSURE_CYCLES,
  output logic VERT_PHASE_A,
  output logic VERT_PHASE_B,
  output logic HORIZ_PHASE_A,
  output logic HORIZ_PHASE_B,
  output logic SPLIT_GATE_LOW_GAIN,
  output logic SPLIT_GATE_HIGH_GAIN,
  output logic RESET_CLK,
  output logic PIXEL_STROBE,
  output logic LINE_DONE,
  output logic FRAME_DONE,
  output logic BUSY
);
  crs_pkg::crs_state_t state_reg;
  crs_pkg::crs_state_t state_next;
  logic [1:0] start_sync_reg;
  logic [1:0] sel_sync_reg;
  logic start_prev_reg;
  logic sel_reg;
  logic sel_next;
  logic [31:0] exp_cnt_reg;
  logic [31:0] exp_cnt_next;
  logic [15:0] setup_cnt_reg;
  logic [15:0] setup_cnt_next;
  logic [10:0] pix_cnt_reg;
  logic [10:0] pix_cnt_next;
  logic [10:0] line_cnt_reg;
  logic [10:0] line_cnt_next;
  logic v_start;
  logic v_a;
  logic v_b;
  logic v_done;
  logic h_a;
  logic h_b;
  logic rst_clk;
  logic pix_end;
  logic run_h;
  logic start_rise;
  logic [31:0] exp_len;
  logic line_end;
  logic frame_end;
  logic hsetup_end;
  logic [1:0] start_sync_next;
  logic [1:0] sel_sync_next;
  logic start_prev_next;
  logic vert_phase_a_next;
  logic vert_phase_b_next;
  logic horiz_phase_a_next;
  logic horiz_phase_b_next;
  logic split_gate_low_gain_next;
  logic split_gate_high_gain_next;
  logic reset_clk_next;
  logic pixel_strobe_next;
  logic line_done_next;
  logic frame_done_next;
  logic busy_next;

  // terminal-count compare shared by the pixel and line counters
  function automatic logic crs_is_last(input logic [10:0] cnt,
    input int n);
    crs_is_last = (cnt == 11'(n - 1));
  endfunction

  // start and output select are asynchronous to the core clock
  always_comb begin
    start_sync_next = {start_sync_reg[0], START};
    sel_sync_next = {sel_sync_reg[0], OUT_SEL};
    start_prev_next = start_sync_reg[1];
  end
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      start_sync_reg <= 2'h0;
      sel_sync_reg <= 2'h0;
      start_prev_reg <= 1'h0;
    end else begin
      start_sync_reg <= start_sync_next;
      sel_sync_reg <= sel_sync_next;
      start_prev_reg <= start_prev_next;
    end
  end
  assign start_rise = start_sync_reg[1] && !start_prev_reg;
  assign exp_len = EXPOSURE_CYCLES;

  crs_vert_seq u_vert (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .start(v_start),
    .v_a(v_a),
    .v_b(v_b),
    .done(v_done)
  );

  // horizontal clocks run only in readout; pixel timebase never stops
  assign run_h = (state_reg == crs_pkg::ST_HREAD);
  crs_pixel_clock u_pix (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .run_h(run_h),
    .h_a(h_a),
    .h_b(h_b),
    .rst_clk(rst_clk),
    .pix_end(pix_end)
  );

  // setup runs on to the next pixel boundary, so the delay from vertical
  // phase a rising to the first horizontal edge is the same on every line after the first;
  // it comes out near 16 us, below nominal, as the line budget wins
  assign hsetup_end =
    (setup_cnt_reg >= 16'(crs_pkg::HSETUP_CYC - 1)) && pix_end; // R11
  assign line_end = (state_reg == crs_pkg::ST_HREAD) && pix_end &&
    crs_is_last(pix_cnt_reg,
      crs_pkg::PIX_PER_LINE + crs_pkg::EXTRA_PIX); // R4
  assign frame_end = line_end &&
    crs_is_last(line_cnt_reg, crs_pkg::LINES_PER_FRAME); // R5
  assign v_start = (state_reg == crs_pkg::ST_VERT) &&
    (setup_cnt_reg == 16'h0000);

  always_comb begin
    state_next = state_reg;
    sel_next = sel_reg;
    exp_cnt_next = exp_cnt_reg;
    setup_cnt_next = setup_cnt_reg;
    pix_cnt_next = pix_cnt_reg;
    line_cnt_next = line_cnt_reg;
    case (state_reg)
      crs_pkg::ST_IDLE: begin
        sel_next = sel_sync_reg[1];
        if (start_rise) begin
          exp_cnt_next = 32'h00000000;
          state_next = crs_pkg::ST_EXPOSE;
        end
      end
      crs_pkg::ST_EXPOSE: begin
        // vertical phases held low for the whole exposure
        exp_cnt_next = exp_cnt_reg + 32'h00000001; // R12 R14
        if (exp_cnt_reg >= exp_len) begin
          line_cnt_next = 11'h000;
          setup_cnt_next = 16'h0000;
          state_next = crs_pkg::ST_VERT;
        end
      end
      crs_pkg::ST_VERT: begin
        // marker: 1 once the vertical sequencer has been kicked
        setup_cnt_next = 16'h0001;
        if (v_done) begin
          setup_cnt_next = 16'h0000;
          state_next = crs_pkg::ST_HSETUP;
        end
      end
      crs_pkg::ST_HSETUP: begin
        // setup ends on a pixel boundary so the first pixel is whole
        setup_cnt_next = setup_cnt_reg + 16'h0001;
        if (hsetup_end) begin
          pix_cnt_next = 11'h000;
          state_next = crs_pkg::ST_HREAD;
        end
      end
      crs_pkg::ST_HREAD: begin
        if (pix_end) begin
          pix_cnt_next = pix_cnt_reg + 11'h001;
        end
        if (frame_end) begin
          state_next = crs_pkg::ST_IDLE;
        end else if (line_end) begin
          line_cnt_next = line_cnt_reg + 11'h001;
          setup_cnt_next = 16'h0000;
          state_next = crs_pkg::ST_VERT;
        end
      end
      default: begin
        state_next = crs_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= crs_pkg::ST_IDLE;
      sel_reg <= crs_pkg::OUT_WIDE;
      exp_cnt_reg <= 32'h00000000;
      setup_cnt_reg <= 16'h0000;
      pix_cnt_reg <= 11'h000;
      line_cnt_reg <= 11'h000;
    end else begin
      state_reg <= state_next;
      sel_reg <= sel_next;
      exp_cnt_reg <= exp_cnt_next;
      setup_cnt_reg <= setup_cnt_next;
      pix_cnt_reg <= pix_cnt_next;
      line_cnt_reg <= line_cnt_next;
    end
  end

  // next pin values; the flops below only register them
  always_comb begin
    vert_phase_a_next = v_a; // R15 R14
    vert_phase_b_next = v_b; // R15 R14
    horiz_phase_a_next = h_a; // R7 R13
    horiz_phase_b_next = h_b; // R7 R13
    // split gates share the flop stage of h_b, so they carry no skew
    split_gate_low_gain_next = crs_pkg::SPLIT_IDLE;
    split_gate_high_gain_next = crs_pkg::SPLIT_IDLE;
    if (sel_reg == crs_pkg::OUT_WIDE) begin
      split_gate_low_gain_next = h_b; // R1
    end else begin
      split_gate_high_gain_next = h_b; // R2
    end
    reset_clk_next = rst_clk; // R3
    pixel_strobe_next = run_h && pix_end;
    line_done_next = line_end;
    frame_done_next = frame_end;
    busy_next = (state_reg != crs_pkg::ST_IDLE);
  end

  // output register stage; every pin is a flip-flop
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      VERT_PHASE_A <= 1'h0;
      VERT_PHASE_B <= 1'h0;
      HORIZ_PHASE_A <= 1'h0;
      HORIZ_PHASE_B <= 1'h0;
      SPLIT_GATE_LOW_GAIN <= 1'h0;
      SPLIT_GATE_HIGH_GAIN <= 1'h0;
      RESET_CLK <= 1'h0;
      PIXEL_STROBE <= 1'h0;
      LINE_DONE <= 1'h0;
      FRAME_DONE <= 1'h0;
      BUSY <= 1'h0;
    end else begin
      VERT_PHASE_A <= vert_phase_a_next;
      VERT_PHASE_B <= vert_phase_b_next;
      HORIZ_PHASE_A <= horiz_phase_a_next;
      HORIZ_PHASE_B <= horiz_phase_b_next;
      SPLIT_GATE_LOW_GAIN <= split_gate_low_gain_next;
      SPLIT_GATE_HIGH_GAIN <= split_gate_high_gain_next;
      RESET_CLK <= reset_clk_next;
      PIXEL_STROBE <= pixel_strobe_next;
      LINE_DONE <= line_done_next;
      FRAME_DONE <= frame_done_next;
      BUSY <= busy_next;
    end
  end
endmodule

// >>> verification/crs_sequencer_asserts.sv
`timescale 1ns/10ps
module crs_sequencer_asserts (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic VERT_PHASE_A,
  input wire logic VERT_PHASE_B,
  input wire logic HORIZ_PHASE_A,
  input wire logic HORIZ_PHASE_B,
  input wire logic SPLIT_GATE_LOW_GAIN,
  input wire logic SPLIT_GATE_HIGH_GAIN,
  input wire logic RESET_CLK,
  input wire logic BUSY,
  input wire logic PIXEL_STROBE,
  input wire logic LINE_DONE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // run length of the vertical phase a high level
  logic [7:0] va_reg;
  logic [7:0] va_next;
  always_comb va_next = VERT_PHASE_A ? va_reg + 8'h01 : 8'h00;
  always_ff @(posedge CORE_CLK or negedge RST_N)
    if (!RST_N)
      va_reg <= 8'h00;
    else
      va_reg <= va_next;
  AST_GATE_ON: assert property (HORIZ_PHASE_B |->
    SPLIT_GATE_LOW_GAIN ^ SPLIT_GATE_HIGH_GAIN) else $error("gate idle");
  AST_GATE_OFF: assert property (!HORIZ_PHASE_B |->
    !SPLIT_GATE_LOW_GAIN && !SPLIT_GATE_HIGH_GAIN) else $error("gate on");
  AST_RST_PW: assert property ($rose(RESET_CLK) |->
    RESET_CLK [*3] ##1 !RESET_CLK) else $error("reset width");
  AST_RST_RUN: assert property (!RESET_CLK [*7] |=>
    RESET_CLK) else $error("reset clock stopped");
  AST_HB_HALF: assert property ($rose(HORIZ_PHASE_B) |->
    HORIZ_PHASE_B [*5] ##1 !HORIZ_PHASE_B) else $error("h duty");
  AST_H_COMPL: assert property ($fell(HORIZ_PHASE_B) |->
    $rose(HORIZ_PHASE_A)) else $error("h not complementary");
  AST_VPW: assert property ($fell(VERT_PHASE_A) |->
    va_reg == 8'hC8) else $error("v width");
  AST_V_SWAP: assert property ($rose(VERT_PHASE_B) |->
    $fell(VERT_PHASE_A)) else $error("v swap");
  AST_V_IDLE: assert property ((!BUSY || HORIZ_PHASE_A) |->
    !VERT_PHASE_A && !VERT_PHASE_B) else $error("v not idle");
  AST_PIX_END: assert property (PIXEL_STROBE |->
    HORIZ_PHASE_A && !HORIZ_PHASE_B) else $error("strobe off phase");
  AST_PIX_PERIOD: assert property (PIXEL_STROBE |->
    ##2 !PIXEL_STROBE [*8] ##1 (PIXEL_STROBE || !HORIZ_PHASE_A))
    else $error("pixel period");
  cover property ($rose(BUSY));
  cover property (LINE_DONE);
  cover property ($rose(SPLIT_GATE_HIGH_GAIN));
endmodule
bind crs_sequencer crs_sequencer_asserts u_chk (.*);

// >>> verification/crs_sensor_model.sv
`timescale 1ns/10ps
// counts packets dumped on each output node during one line
module crs_sensor_model (
  input wire logic clk,
  input wire logic g_wide,
  input wire logic g_sens,
  input wire logic v_b,
  output int n_wide,
  output int n_sens,
  output int n_dark
);
  bit wb;
  bit sb;
  bit vb;
  int col;
  always @(posedge clk) begin
    wb <= g_wide;
    sb <= g_sens;
    vb <= v_b;
    if (v_b && !vb) begin
      col <= 0;
      n_wide <= 0;
      n_sens <= 0;
      n_dark <= 0;
    end else if ((wb && !g_wide) || (sb && !g_sens)) begin
      col <= col + 1;
      n_wide <= n_wide + int'(wb && !g_wide);
      n_sens <= n_sens + int'(sb && !g_sens);
      n_dark <= n_dark + int'(col < 4 || (col >= 1028 && col < 1036));
    end
  end
endmodule

// >>> verification/crs_sequencer_tb.sv
`timescale 1ns/10ps
module crs_sequencer_tb;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic start = 1'h0;
  logic sel = 1'h0;
  logic [31:0] exp_cyc = 32'h0;
  logic va, vb, ha, hb, gl, gh, rc, ps, ld, fd, busy;
  int nw, ns, nd;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int ps_cnt = 0;
  logic fd_seen = 1'h0;
  always #12.5 clk = ~clk;
  // strobes since vertical phase b last rose; frame end must not come
  always @(posedge clk) begin
    if (vb)
      ps_cnt <= 0;
    else if (ps)
      ps_cnt <= ps_cnt + 1;
    if (fd)
      fd_seen <= 1'h1;
  end
  crs_sequencer dut (
    .CORE_CLK(clk),
    .RST_N(rst_n),
    .START(start),
    .OUT_SEL(sel),
    .EXPOSURE_CYCLES(exp_cyc),
    .VERT_PHASE_A(va),
    .VERT_PHASE_B(vb),
    .HORIZ_PHASE_A(ha),
    .HORIZ_PHASE_B(hb),
    .SPLIT_GATE_LOW_GAIN(gl),
    .SPLIT_GATE_HIGH_GAIN(gh),
    .RESET_CLK(rc),
    .PIXEL_STROBE(ps),
    .LINE_DONE(ld),
    .FRAME_DONE(fd),
    .BUSY(busy)
  );
  crs_sensor_model sensor (
    .clk(clk),
    .g_wide(gl),
    .g_sens(gh),
    .v_b(vb),
    .n_wide(nw),
    .n_sens(ns),
    .n_dark(nd)
  );
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      err_total++;
      $display("ERROR %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // two full lines per run keep the run short; a frame would be 11M cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic wait_hi(ref logic s, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (s !== 1'h1 && n < 20000);
  endtask
  task automatic run_frame(input logic s, input logic [31:0] e, output int t);
    int n;
    @(posedge clk);
    sel <= s;
    exp_cyc <= e;
    repeat (4) @(posedge clk);
    start <= 1'h1;
    wait_hi(busy, n);
    check(n <= 8, 1'h1);
    wait_hi(va, t);
    wait_hi(ld, n);
    check(ps, 1'h1);
    check(ps_cnt, 32'h414);
    check(nw, s ? 32'h0 : 32'h415);
    check(ns, s ? 32'h415 : 32'h0);
    check(nd, 32'hC);
    @(posedge clk);
    start <= 1'h0;
    wait_hi(ld, n);
    check(n >= 32'h2B52 && n <= 32'h2B5C, 1'h1);
    check(fd_seen, 1'h0);
    check(busy, 1'h1);
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (3) @(posedge clk);
    check({va, vb, ha, hb, gl, gh, rc, busy}, 32'h0);
    rst_n <= 1'h1;
  endtask
  initial begin
    int t1;
    int t2;
    repeat (10) @(posedge clk);
    check({va, vb, ha, hb, gl, gh, rc, ps, ld, fd, busy}, 32'h0);
    rst_n <= 1'h1;
    run_frame(1'h0, 32'h14, t1);
    run_frame(1'h1, 32'h78, t2);
    check(t2 - t1, 32'h64);
    report_and_stop();
  end
endmodule
